// *** core/bus_release.sv ***
`default_nettype none

// Notes on behaviour
// - A low level on hold_request_n is a pending bus request.
// - Any bus cycle in progress finishes before release starts.
// - Data bus floated at once; address and strobes driven high first, then floated.
// - Grant goes low only after all bus outputs are off.
// - No internal I/O access while released; peripherals keep running.
// - Watchdog keeps counting through the whole release period.
// - Low data byte always floats; upper byte floats only in bus mode.
// - Upper address and chip selects float in bus mode, hold in port mode.
// - Direction pin output off with pull-up on, whatever its latch holds.
// - Request and grant act only when port 5 selects that function.
module bus_release
    import bus_release_pkg::*;
#(
    // Upper address group width; a part with fewer upper pins narrows it.
    parameter int ADDR_HI_BUS_W = ADDR_HI_W
) (
    input wire logic clk,
    input wire logic rst,
    // Core bus side.
    input wire logic core_cycle_active,
    input wire logic [ADDR_LO_W-1:0] core_addr_lo,
    input wire logic [ADDR_HI_BUS_W-1:0] core_addr_hi,
    input wire logic [DATA_LO_W+DATA_HI_W-1:0] core_wdata,
    input wire logic core_data_oe,
    input wire strobe_t core_strobe,
    output logic core_bus_hold,
    output logic io_access_block,
    // Port configuration.
    input wire logic [7:0] port5_direction_reg,
    input wire logic [7:0] port5_function_reg,
    input wire logic upper_data_bus_mode,
    input wire logic upper_addr_bus_mode,
    input wire logic cs_bus_mode,
    input wire logic grant_port_latch,
    // Pins.
    input wire logic hold_request_n,
    output logic hold_grant_n,
    output logic hold_grant_oe,
    output logic [ADDR_LO_W-1:0] addr_lo_o,
    output logic addr_lo_oe,
    output logic [ADDR_HI_BUS_W-1:0] addr_hi_o,
    output logic addr_hi_oe,
    output logic [DATA_LO_W-1:0] data_lo_o,
    output logic data_lo_oe,
    output logic [DATA_HI_W-1:0] data_hi_o,
    output logic data_hi_oe,
    output strobe_t strobe_o,
    output logic strobe_oe,
    output logic cs_oe,
    output logic rw_dir_pullup
);

    // ----------------------------------------------------------------
    // Request pin synchroniser
    // ----------------------------------------------------------------
    logic [SYNC_STAGES-1:0] req_sync_q;
    logic req_level_q;
    logic release_fn;
    logic req_active;

    // Pin is asynchronous; a change counts once stages two and three agree.
    // Stage one may go metastable, so only stages two and three are ever compared.
    always_ff @(posedge clk) begin
        if (rst) begin
            req_sync_q <= '1;
        end else begin
            req_sync_q <= {req_sync_q[SYNC_STAGES-2:0], hold_request_n};
        end
    end

    // Filtered request level, low means pending.
    always_ff @(posedge clk) begin
        if (rst) begin
            req_level_q <= 1'b1;
        end else if (req_sync_q[1] == req_sync_q[2]) begin
            req_level_q <= req_sync_q[2];
        end
    end

    // Pins must be inputs/outputs with the bus function selected to take part.
    // A half-configured pair leaves the bus with the core, which is the safe side.
    assign release_fn = ~port5_direction_reg[P5_REQ_BIT] & port5_function_reg[P5_REQ_BIT]
                      & port5_direction_reg[P5_GRANT_BIT] & port5_function_reg[P5_GRANT_BIT];
    assign req_active = release_fn & ~req_level_q;

    // ----------------------------------------------------------------
    // Release sequencer
    // ----------------------------------------------------------------
    rel_state_t state_q;
    logic [3:0] hi_cnt_q;

    // One state per release step; the request is only looked at in ST_OWN and ST_GRANTED.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_OWN;
        end else begin
            unique case (state_q)
                ST_OWN: begin
                    if (req_active) begin
                        state_q <= ST_WAIT_CYCLE;
                    end
                end
                ST_WAIT_CYCLE: begin
                    // The core is held from here on, so the cycle in flight is the last one.
                    if (!core_cycle_active) begin
                        state_q <= ST_DRIVE_HIGH;
                    end
                end
                ST_DRIVE_HIGH: begin
                    if (hi_cnt_q == DRIVE_HIGH_CNT) begin
                        state_q <= ST_FLOAT;
                    end
                end
                ST_FLOAT: begin
                    state_q <= ST_GRANTED;
                end
                ST_GRANTED: begin
                    if (!req_active) begin
                        state_q <= ST_RETURN;
                    end
                end
                ST_RETURN: begin
                    state_q <= ST_OWN;
                end
                // Two of the eight codes are unused; fall back to owning the bus.
                default: begin
                    state_q <= ST_OWN;
                end
            endcase
        end
    end

    // Counts cycles spent driving the bus high before floating it.
    // It restarts on every entry, so a new release always gets the full count.
    always_ff @(posedge clk) begin
        if (rst) begin
            hi_cnt_q <= 4'h0;
        end else if (state_q == ST_DRIVE_HIGH) begin
            hi_cnt_q <= hi_cnt_q + 4'h1;
        end else begin
            hi_cnt_q <= 4'h0;
        end
    end

    // ----------------------------------------------------------------
    // Next-state pin decode
    // ----------------------------------------------------------------
    logic force_high_d;
    logic floated_d;
    logic granted_d;
    logic hold_d;
    logic pins_released_d;

    // Decoded from the registered state, then registered again at the pins.
    // Every pin therefore lags the state by exactly one cycle, all in step.
    always_comb begin
        force_high_d = (state_q == ST_DRIVE_HIGH);
        floated_d = (state_q == ST_FLOAT) || (state_q == ST_GRANTED);
        granted_d = (state_q == ST_GRANTED);
        hold_d = (state_q != ST_OWN) && (state_q != ST_RETURN);
        pins_released_d = force_high_d || floated_d;
    end

    // Core hold: raised as soon as a request is taken, so the cycle already in
    // flight is the last one and the release cannot be starved by new cycles.
    always_ff @(posedge clk) begin
        if (rst) begin
            core_bus_hold <= 1'b0;
        end else begin
            core_bus_hold <= hold_d;
        end
    end

    // Internal I/O block. Peripherals and the watchdog have no connection here,
    // so they keep running through the release.
    always_ff @(posedge clk) begin
        if (rst) begin
            io_access_block <= 1'b0;
        end else begin
            io_access_block <= floated_d;
        end
    end

    // ----------------------------------------------------------------
    // Grant pin
    // ----------------------------------------------------------------
    // Grant drops one cycle after the float enables go off, so the master never overlaps.
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_grant_n <= 1'b1;
        end else begin
            if (release_fn) begin
                hold_grant_n <= ~granted_d;
            end else begin
                hold_grant_n <= grant_port_latch;
            end
        end
    end

    // Grant enable: the pin drives whenever it is an output, in either function.
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_grant_oe <= 1'b0;
        end else begin
            hold_grant_oe <= release_fn | port5_direction_reg[P5_GRANT_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Address, strobe and data pins
    // ----------------------------------------------------------------
    // Low address and strobes. Chip select bits stay in the strobe struct so it
    // has one driver; in port mode they are left untouched on release.
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_lo_o <= '1;
            addr_lo_oe <= 1'b1;
            strobe_o <= STROBE_IDLE;
            strobe_oe <= 1'b1;
        end else if (pins_released_d) begin
            addr_lo_o <= '1;
            addr_lo_oe <= ~floated_d;
            strobe_o.rd_n <= 1'b1;
            strobe_o.wr_n <= 1'b1;
            strobe_o.upper_write_strobe_n <= 1'b1;
            strobe_o.rw_dir <= 1'b1;
            strobe_oe <= ~floated_d;
            if (cs_bus_mode) begin
                strobe_o.chip_select_n <= '1;
            end
        end else begin
            addr_lo_o <= core_addr_lo;
            addr_lo_oe <= 1'b1;
            strobe_o <= core_strobe;
            strobe_oe <= 1'b1;
        end
    end

    // Upper address. A port-mode group keeps both value and enable frozen, so
    // whatever the port logic left on those pins survives the release.
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_hi_o <= '1;
            addr_hi_oe <= 1'b1;
        end else if (upper_addr_bus_mode) begin
            if (pins_released_d) begin
                addr_hi_o <= '1;
                addr_hi_oe <= ~floated_d;
            end else begin
                addr_hi_o <= core_addr_hi;
                addr_hi_oe <= 1'b1;
            end
        end
    end

    // Chip select enables follow the same drive-high-then-float order.
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_oe <= 1'b1;
        end else if (cs_bus_mode) begin
            cs_oe <= ~floated_d;
        end
    end

    // Direction pin: the pull-up replaces the driver only while floated, so the
    // external master sees a defined high even if the latch holds a low.
    always_ff @(posedge clk) begin
        if (rst) begin
            rw_dir_pullup <= 1'b0;
        end else begin
            rw_dir_pullup <= floated_d;
        end
    end

    // Data bus: low byte always floats on release, upper byte only in bus mode.
    // Port-mode upper data keeps its last value and enable; the port logic owns it.
    always_ff @(posedge clk) begin
        if (rst) begin
            data_lo_o <= '0;
            data_lo_oe <= 1'b0;
            data_hi_o <= '0;
            data_hi_oe <= 1'b0;
        end else if (pins_released_d) begin
            data_lo_oe <= 1'b0;
            if (upper_data_bus_mode) begin
                data_hi_oe <= 1'b0;
            end
        end else begin
            data_lo_o <= core_wdata[DATA_LO_W-1:0];
            data_lo_oe <= core_data_oe;
            if (upper_data_bus_mode) begin
                data_hi_o <= core_wdata[DATA_LO_W+DATA_HI_W-1:DATA_LO_W];
                data_hi_oe <= core_data_oe;
            end
        end
    end

endmodule

`default_nettype wire

// *** core/bus_release_pkg.sv ***
`default_nettype none

package bus_release_pkg;

    // ----------------------------------------------------------------
    // Bus widths and pin groups
    // ----------------------------------------------------------------
    localparam int ADDR_LO_W = 16;
    localparam int ADDR_HI_W = 8;
    localparam int DATA_LO_W = 8;
    localparam int DATA_HI_W = 8;
    localparam int CS_W = 4;
    localparam int SYNC_STAGES = 3;

    // ----------------------------------------------------------------
    // Port 5 bit positions of the shared request and grant pins
    // ----------------------------------------------------------------
    localparam int P5_REQ_BIT = 3;
    localparam int P5_GRANT_BIT = 4;
    localparam logic [7:0] P5_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Release sequencing: cycles of forced-high drive before floating
    // ----------------------------------------------------------------
    localparam int DRIVE_HIGH_NS = 4;
    localparam int CLK_PERIOD_NS = 4;
    localparam int DRIVE_HIGH_CYC = (DRIVE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] DRIVE_HIGH_CNT = 4'(DRIVE_HIGH_CYC);

    // Control strobes grouped so they travel together.
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic upper_write_strobe_n;
        logic rw_dir;
        logic [CS_W-1:0] chip_select_n;
    } strobe_t;

    localparam strobe_t STROBE_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 4'hf};

    typedef enum logic [2:0] {
        ST_OWN,
        ST_WAIT_CYCLE,
        ST_DRIVE_HIGH,
        ST_FLOAT,
        ST_GRANTED,
        ST_RETURN
    } rel_state_t;

endpackage

`default_nettype wire

// *** testbench/ext_master.sv ***
`default_nettype none

// ------------
// Far-side bus master
// ------------
module ext_master (
    input wire logic clk,
    input wire logic rst,
    input wire logic want,
    input wire logic hold_grant_n,
    output logic hold_request_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // The request is a plain level that changes only after an edge.
    // Dropping it before the grant is left to the bench, which only does so when refused.
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_request_n <= 1'h1;
        end else begin
            hold_request_n <= !want;
        end
    end
endmodule

`default_nettype wire

// *** testbench/bus_release_sva.sv ***
`default_nettype none

// ------------
// Release checks
// ------------
module bus_release_sva
    import bus_release_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hold_request_n,
    input wire logic upper_data_bus_mode,
    input wire logic upper_addr_bus_mode,
    input wire logic cs_bus_mode,
    input wire logic hold_grant_n,
    input wire logic [ADDR_LO_W-1:0] addr_lo_o,
    input wire logic addr_lo_oe,
    input wire logic addr_hi_oe,
    input wire logic data_lo_oe,
    input wire logic [DATA_HI_W-1:0] data_hi_o,
    input wire logic data_hi_oe,
    input wire strobe_t strobe_o,
    input wire logic strobe_oe,
    input wire logic cs_oe,
    input wire logic io_access_block,
    input wire logic core_bus_hold,
    input wire logic rw_dir_pullup
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Every driver of the low bus is off.
    sequence s_floated;
        !addr_lo_oe && !strobe_oe && !data_lo_oe;
    endsequence

    // Port-mode chip selects keep their state, so they only count in bus mode.
    a_high_before_off: assert property ($fell(addr_lo_oe) |->
        $past(addr_lo_o) == 16'hffff
        && $past(strobe_o.rd_n & strobe_o.wr_n & strobe_o.upper_write_strobe_n & strobe_o.rw_dir)
        && (!cs_bus_mode || $past(strobe_o.chip_select_n) == 4'hf)) else $error("bus not high before float");
    a_core_held: assert property (!addr_lo_oe |-> core_bus_hold) else $error("core free while floated");
    a_grant_after_off: assert property ($fell(hold_grant_n) |-> s_floated) else $error("grant before float");
    a_release_blocks: assert property (!hold_grant_n |-> io_access_block && rw_dir_pullup)
        else $error("io or pull-up wrong");
    a_upper_data_off: assert property (!hold_grant_n && upper_data_bus_mode |-> !data_hi_oe)
        else $error("upper data driven");
    a_upper_data_kept: assert property (!hold_grant_n && !upper_data_bus_mode |->
        $stable(data_hi_o) && $stable(data_hi_oe)) else $error("port data moved");
    a_addr_cs_off: assert property (!hold_grant_n && upper_addr_bus_mode && cs_bus_mode |->
        !addr_hi_oe && !cs_oe) else $error("upper address driven");
    a_grant_stays: assert property (!hold_grant_n && !hold_request_n |=> !hold_grant_n)
        else $error("grant dropped early");
    a_return_drive: assert property ($rose(hold_grant_n) |-> addr_lo_oe && strobe_oe)
        else $error("drivers not back");
endmodule

bind bus_release bus_release_sva u_sva (.clk, .rst, .hold_request_n, .upper_data_bus_mode,
    .upper_addr_bus_mode, .cs_bus_mode, .hold_grant_n, .addr_lo_o, .addr_lo_oe, .addr_hi_oe,
    .data_lo_oe, .data_hi_o, .data_hi_oe, .strobe_o, .strobe_oe, .cs_oe, .io_access_block, .core_bus_hold,
    .rw_dir_pullup);

`default_nettype wire

// *** testbench/testbench.sv ***
`default_nettype none

// ------------
// Bench top
// ------------
module testbench
    import bus_release_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'h0, rst = 1'h1, core_cycle_active = 1'h0, core_data_oe = 1'h0, want = 1'h0;
    logic [15:0] core_addr_lo = 16'h0, core_wdata = 16'h0, addr_lo_o;
    logic [7:0] core_addr_hi = 8'h0, port5_function_reg = 8'h18, port5_direction_reg = 8'h10;
    logic upper_data_bus_mode = 1'h1, upper_addr_bus_mode = 1'h1, cs_bus_mode = 1'h1, grant_port_latch = 1'h1;
    strobe_t core_strobe = STROBE_IDLE, strobe_o;
    logic core_bus_hold, io_access_block, hold_request_n, hold_grant_n, hold_grant_oe, rw_dir_pullup;
    logic addr_lo_oe, addr_hi_oe, data_lo_oe, data_hi_oe, strobe_oe, cs_oe;
    logic [7:0] addr_hi_o, data_lo_o, data_hi_o;
    logic [31:0] seed = 32'h1dfe;
    int n_mismatch = 0, checks_done = 0;

    bus_release u_bus_release (.clk, .rst, .core_cycle_active, .core_addr_lo, .core_addr_hi, .core_wdata,
        .core_data_oe, .core_strobe, .core_bus_hold, .io_access_block, .port5_direction_reg,
        .port5_function_reg, .upper_data_bus_mode, .upper_addr_bus_mode, .cs_bus_mode, .grant_port_latch,
        .hold_request_n, .hold_grant_n, .hold_grant_oe, .addr_lo_o, .addr_lo_oe, .addr_hi_o, .addr_hi_oe,
        .data_lo_o, .data_lo_oe, .data_hi_o, .data_hi_oe, .strobe_o, .strobe_oe, .cs_oe, .rw_dir_pullup);
    ext_master u_ext_master (.clk, .rst, .want, .hold_grant_n, .hold_request_n);

    // Free-running clock; every input but hold_request_n moves 1 ns after the rising edge.
    initial forever #2 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One request raised during a busy core cycle, then dropped after the grant.
    // A refused request is dropped after a fixed wait, which is why the far side may abort.
    task automatic run(input logic bus, input logic fn);
        int n;
        logic [7:0] ah;
        seed = lfsr(seed);
        {upper_data_bus_mode, upper_addr_bus_mode, cs_bus_mode} = {3{bus}};
        port5_function_reg = fn ? 8'h18 : 8'h10;
        {core_addr_hi, core_wdata, core_strobe} = seed;
        core_addr_lo = seed[31:16];
        core_data_oe = seed[3];
        core_cycle_active = 1'h1;
        want = 1'h1;
        for (n = 0; n < 6 + seed[27:24]; n++) begin
            step();
            check({hold_grant_n, addr_lo_oe}, 2'h3);
        end
        core_cycle_active = 1'h0;
        n = 0;
        while (hold_grant_n !== 1'h0 && n < 20) begin
            step();
            n++;
        end
        if (fn) begin
            check(n >= 3 && n <= 8, 1'h1);
            check({io_access_block, rw_dir_pullup, addr_lo_oe, data_lo_oe, strobe_oe, core_bus_hold, hold_grant_oe},
                7'h63);
            if (bus) check({data_hi_oe, addr_hi_oe, cs_oe}, 3'h0);
            ah = addr_hi_o;
            core_addr_hi = ~core_addr_hi;
            repeat (4) step();
            check(hold_grant_n, 1'h0);
            if (!bus) check(addr_hi_o, ah);
            want = 1'h0;
            n = 0;
            while (hold_grant_n !== 1'h1 && n < 20) begin
                step();
                n++;
            end
            check(n <= 8, 1'h1);
            check({addr_lo_oe, strobe_oe, io_access_block, core_bus_hold, data_lo_oe}, {4'hc, core_data_oe});
            check({addr_lo_o, strobe_o, data_lo_o}, {core_addr_lo, core_strobe, core_wdata[7:0]});
        end else begin
            check(n, 20);
            check({addr_lo_oe, core_bus_hold, hold_grant_n}, 3'h5);
            want = 1'h0;
        end
        repeat (6) step();
    endtask

    initial begin
        repeat (4) step();
        rst = 1'h0;
        check({hold_grant_n, addr_lo_o, data_lo_oe}, 18'h3fffe);
        run(1'h1, 1'h1);
        run(1'h0, 1'h1);
        run(1'h1, 1'h0);
        repeat (3) run(seed[5], 1'h1);
        results();
    end

    // Six short runs fit far inside this span; reaching it means a hang.
    initial begin
        #40000;
        n_mismatch++;
        results();
    end
endmodule

`default_nettype wire
